// ==== design/svrs_params.svh ====
// Constants of the sampled-value receive supervisor
`ifndef SVRS_PARAMS_SVH
`define SVRS_PARAMS_SVH
`define SVRS_CLK_MHZ 100
`define SVRS_HOLD_TIME_MS 10000
`define SVRS_HOLD_CYCLES (`SVRS_HOLD_TIME_MS * 1000 * `SVRS_CLK_MHZ)
`define SVRS_COARSE_ACC_MS 100
`define SVRS_COARSE_ACC_NS (`SVRS_COARSE_ACC_MS * 1000000)
`define SVRS_FINE_ACC_US 4
`define SVRS_FINE_ACC_NS (`SVRS_FINE_ACC_US * 1000)
`define SVRS_QUAL_W 14
`define SVRS_QUAL_TEST_BIT 11
`define SVRS_QUAL_DERIVED_BIT 13
`define SVRS_SAMPLE_W 32
`define SVRS_WAIT_W 16
`define SVRS_MISS_ALARM 2
`endif

// ==== design/svrs_pkg.sv ====
// Types of the sampled-value receive supervisor
package svrs_pkg;
   // Frame slot states, Gray along idle, wait, push
   typedef enum logic [1:0] {
      SVRS_IDLE = 2'h0,
      SVRS_WAIT = 2'h1,
      SVRS_PUSH = 2'h3
   } svrs_slot_t;
   // Sender operation setting codes
   typedef enum logic [2:0] {
      SVRS_OP_ON = 3'h1,
      SVRS_OP_OFF = 3'h5
   } svrs_op_t;
endpackage

// ==== design/svrs_hold_timer.sv ====
// Minimum hold stretcher for a fault condition
`timescale 1ns/10ps
module svrs_hold_timer #(
   parameter int unsigned HOLD = 1000,
   parameter int CW = $clog2(HOLD + 1)
) (
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   input wire logic i_cond,
   output logic o_active
);
   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;

   // Reloads every cycle the condition stands, so the hold restarts after it clears
   always_comb begin
      if (i_cond) begin
         cnt_nxt = CW'(HOLD);
      end else if (cnt_r != '0) begin
         cnt_nxt = cnt_r - CW'(1);
      end else begin
         cnt_nxt = '0;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_reset_n) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   assign o_active = i_cond || (cnt_r != '0);
endmodule

// ==== design/svrs_skid_buf.sv ====
// Two-entry buffer with registered outputs on both sides
`timescale 1ns/10ps
module svrs_skid_buf #(
   parameter int W = 160
) (
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [W-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [W-1:0] o_out_data
);
   logic out_v_r, out_v_nxt, sp_v_r, sp_v_nxt;
   logic [W-1:0] out_d_r, out_d_nxt, sp_d_r, sp_d_nxt;
   logic push, pop;

   // Ready depends only on the spare slot, so it is a plain flop
   always_comb begin
      push = i_in_valid && !sp_v_r;
      pop = out_v_r && i_out_ready;
      out_v_nxt = out_v_r;
      out_d_nxt = out_d_r;
      sp_v_nxt = sp_v_r;
      sp_d_nxt = sp_d_r;
      if (pop) begin
         out_v_nxt = 1'b0;
      end
      if (sp_v_r && !out_v_nxt) begin
         out_v_nxt = 1'b1;
         out_d_nxt = sp_d_r;
         sp_v_nxt = 1'b0;
      end
      if (push) begin
         if (!out_v_nxt) begin
            out_v_nxt = 1'b1;
            out_d_nxt = i_in_data;
         end else begin
            sp_v_nxt = 1'b1;
            sp_d_nxt = i_in_data;
         end
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_reset_n) begin
         out_v_r <= 1'b0;
         sp_v_r <= 1'b0;
         out_d_r <= '0;
         sp_d_r <= '0;
      end else begin
         out_v_r <= out_v_nxt;
         sp_v_r <= sp_v_nxt;
         out_d_r <= out_d_nxt;
         sp_d_r <= sp_d_nxt;
      end
   end

   assign o_in_ready = !sp_v_r;
   assign o_out_valid = out_v_r;
   assign o_out_data = out_d_r;
endmodule

// ==== design/svrs_supervisor.sv ====
// Sampled-value receive supervisor: frame slots, alarms, sender operation
//
// Overview of operation
// - Alarm when either side's sync accuracy is unknown or worse than 100 ms.
// - Sync faults keep alarm or warning on 10 s after clearing.
// - Alarm when two or more consecutive frames are missing or late.
// - A single missing frame repeats the last values, no warning or alarm.
// - Frame-loss alarm stays on 10 s after frames return.
// - Frame wait limit sets how long a slot waits before a frame is late.
// - Local samples are delayed by the same wait to stay aligned.
// - Breaker open input drives the voltage fail block output.
// - Warning when either side's sync accuracy is worse than 4 us.
// - Warning when frequency adaptivity is enabled but not ready.
// - Warning is always on while alarm is on.
// - Any quality bit except derived raises warning and alarm.
// - In test mode the test bit is accepted without warning or alarm.
// - Sender operation code 1 is on (default), 5 is off and stops sending.
// - Sender switched off from the local panel re-enables only from there, until a remote off write clears the panel lock.
// - Sender enable adds or removes its control block and data set.
// - Four signed 32-bit voltages are delivered: phases 1 to 3 and residual.
`timescale 1ns/10ps
`include "svrs_params.svh"
module svrs_supervisor #(
   parameter int unsigned HOLD_CYCLES = `SVRS_HOLD_CYCLES,
   parameter int WAIT_W = `SVRS_WAIT_W
) (
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   input wire logic i_snd_acc_known,
   input wire logic [31:0] i_snd_acc_ns,
   input wire logic i_rcv_acc_known,
   input wire logic [31:0] i_rcv_acc_ns,
   input wire logic i_freq_adapt_en,
   input wire logic i_freq_adapt_ready,
   input wire logic i_test_mode,
   input wire logic i_sample_tick,
   input wire logic signed [`SVRS_SAMPLE_W-1:0] i_local_sample,
   input wire logic [WAIT_W-1:0] i_frame_wait_limit,
   input wire logic i_frame_valid,
   output logic o_frame_ready,
   input wire logic [`SVRS_QUAL_W-1:0] i_frame_quality,
   input wire logic signed [`SVRS_SAMPLE_W-1:0] i_phase1_voltage,
   input wire logic signed [`SVRS_SAMPLE_W-1:0] i_phase2_voltage,
   input wire logic signed [`SVRS_SAMPLE_W-1:0] i_phase3_voltage,
   input wire logic signed [`SVRS_SAMPLE_W-1:0] i_residual_voltage,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic signed [`SVRS_SAMPLE_W-1:0] o_phase1_voltage,
   output logic signed [`SVRS_SAMPLE_W-1:0] o_phase2_voltage,
   output logic signed [`SVRS_SAMPLE_W-1:0] o_phase3_voltage,
   output logic signed [`SVRS_SAMPLE_W-1:0] o_residual_voltage,
   output logic signed [`SVRS_SAMPLE_W-1:0] o_local_sample,
   input wire logic i_breaker_open_in,
   output logic o_voltage_fail_block,
   input wire logic i_sender_op_wr,
   input wire logic [2:0] i_sender_op_val,
   input wire logic i_sender_op_from_panel,
   output logic o_sender_active,
   output logic o_alarm,
   output logic o_warning
);
   localparam int SW = `SVRS_SAMPLE_W;
   localparam int WW = 5 * SW;

   // =====================================================
   // Decoding
   // =====================================================
   function automatic logic qual_fault(input logic [`SVRS_QUAL_W-1:0] q, input logic test_mode);
      logic [`SVRS_QUAL_W-1:0] m;
      m = q;
      m[`SVRS_QUAL_DERIVED_BIT] = 1'b0;
      if (test_mode) begin
         m[`SVRS_QUAL_TEST_BIT] = 1'b0;
      end
      return |m;
   endfunction

   // =====================================================
   // Frame slot
   // =====================================================
   svrs_pkg::svrs_slot_t slot_r, slot_nxt;
   logic [WAIT_W-1:0] wait_cnt_r, wait_cnt_nxt;
   logic got_r, got_nxt;
   logic rdy_r, rdy_nxt;
   logic [1:0] miss_r, miss_nxt;
   logic qual_bad_r, qual_bad_nxt;
   logic [4*SW-1:0] frm_r, frm_nxt, held_r, held_nxt;
   logic [SW-1:0] loc_r, loc_nxt;
   logic [WW-1:0] push_r, push_nxt;
   logic accept, slot_end, buf_in_ready, buf_out_valid;
   logic [WW-1:0] buf_out_data;

   assign accept = i_frame_valid && rdy_r;
   // Slot lasts the wait limit, at least one cycle
   assign slot_end = ({1'b0, wait_cnt_r} + (WAIT_W + 1)'(1)) >= {1'b0, i_frame_wait_limit};

   always_comb begin
      slot_nxt = slot_r;
      wait_cnt_nxt = wait_cnt_r;
      got_nxt = got_r;
      miss_nxt = miss_r;
      qual_bad_nxt = qual_bad_r;
      frm_nxt = frm_r;
      held_nxt = held_r;
      loc_nxt = loc_r;
      push_nxt = push_r;
      if (accept) begin
         got_nxt = 1'b1;
         frm_nxt = {i_phase1_voltage, i_phase2_voltage, i_phase3_voltage, i_residual_voltage};
         qual_bad_nxt = qual_fault(i_frame_quality, i_test_mode);
      end
      unique case (slot_r)
         svrs_pkg::SVRS_IDLE: begin
            if (i_sample_tick) begin
               slot_nxt = svrs_pkg::SVRS_WAIT;
               wait_cnt_nxt = '0;
               got_nxt = 1'b0;
               loc_nxt = i_local_sample;
            end
         end
         svrs_pkg::SVRS_WAIT: begin
            if (slot_end) begin
               slot_nxt = svrs_pkg::SVRS_PUSH;
               if (got_nxt) begin
                  miss_nxt = 2'h0;
                  held_nxt = frm_nxt;
                  push_nxt = {frm_nxt, loc_r};
               end else begin
                  // Zero-order hold: repeat last values on a missing frame
                  miss_nxt = (miss_r == 2'h3) ? 2'h3 : miss_r + 2'h1;
                  push_nxt = {held_r, loc_r};
               end
            end else begin
               wait_cnt_nxt = wait_cnt_r + WAIT_W'(1);
            end
         end
         svrs_pkg::SVRS_PUSH: begin
            // Ticks here are dropped; a stalled receiver stretches the slot
            if (buf_in_ready) begin
               slot_nxt = svrs_pkg::SVRS_IDLE;
            end
         end
      endcase
      rdy_nxt = (slot_nxt == svrs_pkg::SVRS_WAIT) && !got_nxt;
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_reset_n) begin
         slot_r <= svrs_pkg::SVRS_IDLE;
         wait_cnt_r <= '0;
         got_r <= 1'b0;
         rdy_r <= 1'b0;
         miss_r <= 2'h0;
         qual_bad_r <= 1'b0;
         frm_r <= '0;
         held_r <= '0;
         loc_r <= '0;
         push_r <= '0;
      end else begin
         slot_r <= slot_nxt;
         wait_cnt_r <= wait_cnt_nxt;
         got_r <= got_nxt;
         rdy_r <= rdy_nxt;
         miss_r <= miss_nxt;
         qual_bad_r <= qual_bad_nxt;
         frm_r <= frm_nxt;
         held_r <= held_nxt;
         loc_r <= loc_nxt;
         push_r <= push_nxt;
      end
   end

   svrs_skid_buf #(.W(WW)) u_buf (
      .i_ref_clk(i_ref_clk),
      .i_reset_n(i_reset_n),
      .i_in_valid(slot_r == svrs_pkg::SVRS_PUSH),
      .o_in_ready(buf_in_ready),
      .i_in_data(push_r),
      .o_out_valid(buf_out_valid),
      .i_out_ready(i_out_ready),
      .o_out_data(buf_out_data)
   );

   assign o_frame_ready = rdy_r;
   assign o_out_valid = buf_out_valid;
   assign o_phase1_voltage = buf_out_data[5*SW-1:4*SW];
   assign o_phase2_voltage = buf_out_data[4*SW-1:3*SW];
   assign o_phase3_voltage = buf_out_data[3*SW-1:2*SW];
   assign o_residual_voltage = buf_out_data[2*SW-1:SW];
   assign o_local_sample = buf_out_data[SW-1:0];

   // =====================================================
   // Alarm and warning
   // =====================================================
   logic coarse_bad, fine_bad, loss_bad, adapt_bad;
   logic alarm_cond, warn_cond, alarm_act, warn_act;
   logic alarm_r, warn_r, vfb_r;

   assign coarse_bad = !i_snd_acc_known || !i_rcv_acc_known
      || (i_snd_acc_ns > 32'(`SVRS_COARSE_ACC_NS)) || (i_rcv_acc_ns > 32'(`SVRS_COARSE_ACC_NS));
   assign fine_bad = (i_snd_acc_known && i_snd_acc_ns > 32'(`SVRS_FINE_ACC_NS))
      || (i_rcv_acc_known && i_rcv_acc_ns > 32'(`SVRS_FINE_ACC_NS));
   assign loss_bad = miss_r >= 2'(`SVRS_MISS_ALARM);
   assign adapt_bad = i_freq_adapt_en && !i_freq_adapt_ready;
   assign alarm_cond = coarse_bad || loss_bad || qual_bad_r;
   assign warn_cond = fine_bad || adapt_bad || qual_bad_r;

   // One shared stretcher per output; a new fault restarts the hold
   svrs_hold_timer #(.HOLD(HOLD_CYCLES)) u_alarm_hold (
      .i_ref_clk(i_ref_clk),
      .i_reset_n(i_reset_n),
      .i_cond(alarm_cond),
      .o_active(alarm_act)
   );

   svrs_hold_timer #(.HOLD(HOLD_CYCLES)) u_warn_hold (
      .i_ref_clk(i_ref_clk),
      .i_reset_n(i_reset_n),
      .i_cond(warn_cond),
      .o_active(warn_act)
   );

   always_ff @(posedge i_ref_clk) begin
      if (!i_reset_n) begin
         alarm_r <= 1'b0;
         warn_r <= 1'b0;
         vfb_r <= 1'b0;
      end else begin
         alarm_r <= alarm_act;
         warn_r <= warn_act || alarm_act;
         vfb_r <= i_breaker_open_in;
      end
   end

   assign o_alarm = alarm_r;
   assign o_warning = warn_r;
   assign o_voltage_fail_block = vfb_r;

   // =====================================================
   // Sender operation
   // =====================================================
   logic snd_on_r, snd_on_nxt, panel_lock_r, panel_lock_nxt;

   always_comb begin
      snd_on_nxt = snd_on_r;
      panel_lock_nxt = panel_lock_r;
      if (i_sender_op_wr) begin
         if (i_sender_op_val == svrs_pkg::SVRS_OP_OFF) begin
            snd_on_nxt = 1'b0;
            panel_lock_nxt = i_sender_op_from_panel;
         end else if (i_sender_op_val == svrs_pkg::SVRS_OP_ON) begin
            if (!panel_lock_r || i_sender_op_from_panel) begin
               snd_on_nxt = 1'b1;
               panel_lock_nxt = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_reset_n) begin
         snd_on_r <= 1'b1;
         panel_lock_r <= 1'b0;
      end else begin
         snd_on_r <= snd_on_nxt;
         panel_lock_r <= panel_lock_nxt;
      end
   end

   // Gates both transmission and the presence of control block and data set
   assign o_sender_active = snd_on_r;

   // =====================================================
   // Checks
   // =====================================================
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_reset_n);

   chk_breaker_block: assert property (i_breaker_open_in |=> o_voltage_fail_block)
      else $error("voltage fail block missed breaker open");
   chk_coarse_alarm: assert property (coarse_bad |=> o_alarm)
      else $error("alarm missed coarse sync fault");
   chk_fine_warn: assert property (fine_bad |=> o_warning)
      else $error("warning missed fine sync fault");
   chk_adapt_warn: assert property (adapt_bad |=> o_warning)
      else $error("warning missed adaptivity not ready");
   chk_warn_covers_alarm: assert property (o_alarm |-> o_warning)
      else $error("alarm without warning");
   chk_loss_alarm: assert property (miss_r >= 2'h2 |=> o_alarm)
      else $error("alarm missed frame loss");
   chk_alarm_hold: assert property (!alarm_cond && $past(alarm_cond) && $past(i_reset_n) |=> o_alarm [*2])
      else $error("alarm released without hold");
   chk_single_miss_repeat: assert property (slot_r == svrs_pkg::SVRS_WAIT && slot_end && !got_nxt
      |=> push_r[WW-1:SW] == $past(held_r) && held_r == $past(held_r))
      else $error("missing frame did not repeat held values");
   chk_quality_both: assert property (qual_bad_r |=> o_alarm && o_warning)
      else $error("quality fault not flagged");
   chk_test_accept: assert property (accept && i_test_mode
      && (i_frame_quality & ~`SVRS_QUAL_W'(1 << `SVRS_QUAL_TEST_BIT)) == '0 |=> !qual_bad_r)
      else $error("test frame flagged in test mode");
   chk_wait_bound: assert property (slot_r == svrs_pkg::SVRS_WAIT
      |-> {1'b0, wait_cnt_r} < {1'b0, i_frame_wait_limit} || wait_cnt_r == '0)
      else $error("slot waited past the limit");
   chk_panel_lock: assert property (panel_lock_r && !o_sender_active && i_sender_op_wr
      && !i_sender_op_from_panel |=> !o_sender_active)
      else $error("remote enable overrode panel lock");
   chk_op_off: assert property (i_sender_op_wr && i_sender_op_val == svrs_pkg::SVRS_OP_OFF
      |=> !o_sender_active)
      else $error("sender not switched off");

   cov_single_miss: cover property (slot_r == svrs_pkg::SVRS_WAIT && slot_end && !got_nxt && miss_r == 2'h0);
   cov_loss_alarm: cover property (loss_bad ##1 o_alarm);
   cov_buf_stall: cover property (slot_r == svrs_pkg::SVRS_PUSH && !buf_in_ready);
   cov_panel_lock: cover property (panel_lock_r && i_sender_op_wr && !i_sender_op_from_panel);
endmodule

// ==== tb/svrs_sender_model.sv ====
// Behavioural remote sample stream sender facing the supervisor
`timescale 1ns/10ps
module svrs_sender_model (
   input wire logic i_ref_clk,
   input wire logic i_go,
   input wire logic [7:0] i_delay,
   input wire logic [13:0] i_quality,
   input wire logic [127:0] i_word,
   input wire logic i_frame_ready,
   output logic o_frame_valid,
   output logic [13:0] o_frame_quality,
   output logic [127:0] o_word
);
   int n;
   // ==========================================
   // One frame offered per request
   initial begin
      o_frame_valid = 1'b0;
      o_frame_quality = 14'h0;
      o_word = 128'h0;
      forever begin
         @(posedge i_ref_clk iff i_go);
         repeat (i_delay) @(posedge i_ref_clk);
         @(negedge i_ref_clk);
         o_frame_valid = 1'b1;
         o_frame_quality = i_quality;
         o_word = i_word;
         n = 0;
         // A late frame is dropped by the network, not held for ever
         do begin
            @(posedge i_ref_clk);
            n++;
         end while (!i_frame_ready && n < 3);
         @(negedge i_ref_clk);
         o_frame_valid = 1'b0;
         // Released lines never keep the last frame
         o_frame_quality = ~o_frame_quality;
         o_word = ~o_word;
      end
   end
endmodule

// ==== tb/svrs_supervisor_test.sv ====
// Self-checking bench for the sampled-value receive supervisor
`timescale 1ns/10ps
module svrs_supervisor_test;
   localparam int HOLD = 20;
   localparam int LIM = 6;
   localparam logic [4:0] OPS [7] = '{5'h14, 5'h05, 5'h16, 5'h04, 5'h0A, 5'h07, 5'h0D};
   logic clk = 1'b0, rst_n = 1'b0, sk = 1'b1, rk = 1'b1, fa_en = 1'b0, fa_rdy = 1'b0;
   logic tmode = 1'b0, tick = 1'b0, ordy = 1'b1, brk = 1'b0, opwr = 1'b0, panel = 1'b0;
   logic go = 1'b0, stall = 1'b0, fvalid, fready, ovalid, vfb, sact, alarm, warn;
   logic [31:0] sacc = 32'h0, racc = 32'h0, loc = 32'h0, o1, o2, o3, o0, ol;
   logic [2:0] opval = 3'h1;
   logic [7:0] dly = 8'h0;
   logic [15:0] lim = 16'(LIM);
   logic [13:0] fq, pq = 14'h0;
   logic [127:0] fw, pw = 128'h0, last = 128'h0;
   logic [159:0] e, g;
   logic [159:0] expq[$];
   int miscompares = 0, tests_run = 0;
   // ==========================================
   // Clock, far side and device
   initial begin
      forever #5 clk = ~clk;
   end
   always @(negedge clk) ordy <= stall ? 1'b0 : 1'($urandom);
   svrs_sender_model sender (.i_ref_clk(clk), .i_go(go), .i_delay(dly), .i_quality(pq), .i_word(pw),
      .i_frame_ready(fready), .o_frame_valid(fvalid), .o_frame_quality(fq), .o_word(fw));
   svrs_supervisor #(.HOLD_CYCLES(HOLD)) DUT (.i_ref_clk(clk), .i_reset_n(rst_n),
      .i_snd_acc_known(sk), .i_snd_acc_ns(sacc), .i_rcv_acc_known(rk), .i_rcv_acc_ns(racc),
      .i_freq_adapt_en(fa_en), .i_freq_adapt_ready(fa_rdy), .i_test_mode(tmode),
      .i_sample_tick(tick), .i_local_sample(loc), .i_frame_wait_limit(lim),
      .i_frame_valid(fvalid), .o_frame_ready(fready), .i_frame_quality(fq),
      .i_phase1_voltage(fw[127:96]), .i_phase2_voltage(fw[95:64]), .i_phase3_voltage(fw[63:32]),
      .i_residual_voltage(fw[31:0]), .o_out_valid(ovalid), .i_out_ready(ordy),
      .o_phase1_voltage(o1), .o_phase2_voltage(o2), .o_phase3_voltage(o3),
      .o_residual_voltage(o0), .o_local_sample(ol), .i_breaker_open_in(brk),
      .o_voltage_fail_block(vfb), .i_sender_op_wr(opwr), .i_sender_op_val(opval),
      .i_sender_op_from_panel(panel), .o_sender_active(sact), .o_alarm(alarm), .o_warning(warn));
   // ==========================================
   // Checking and closing
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      tests_run++;
      if (got !== ex) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge clk);
      miscompares++;
      wrap_up();
   end
   // Every delivered word against the model queue
   always @(posedge clk) begin
      if (rst_n && ovalid && ordy) begin
         e = expq.size() != 0 ? expq.pop_front() : '1;
         g = {o1, o2, o3, o0, ol};
         for (int k = 0; k < 5; k++) begin
            chk("output word", e[k*32+:32], g[k*32+:32]);
         end
      end
   end
   // ==========================================
   // One frame slot; a delay of the wait limit or more makes the frame late
   task automatic slot(input int d, input logic [13:0] q);
      @(negedge clk);
      tick = 1'b1;
      go = 1'b1;
      loc = $urandom;
      dly = d[7:0];
      pq = q;
      pw = {$urandom, $urandom, $urandom, $urandom};
      if (d < lim) begin
         last = pw;
      end
      expq.push_back({last, loc});
      @(negedge clk);
      tick = 1'b0;
      go = 1'b0;
      repeat (LIM + 10) @(negedge clk);
   endtask
   initial begin
      void'($urandom(32'hCD5D990A));
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      chk("sender default", 1, sact);
      chk("alarm after reset", 0, alarm);
      for (int i = 0; i < 6; i++) begin
         slot($urandom % LIM, 14'h0);
      end
      slot(LIM - 1, 14'h0);
      slot(LIM, 14'h0);
      chk("single miss alarm", 0, alarm);
      chk("single miss warning", 0, warn);
      slot(0, 14'h0);
      slot(LIM + 4, 14'h0);
      slot(LIM + 4, 14'h0);
      chk("double miss alarm", 1, alarm);
      chk("double miss warning", 1, warn);
      slot(0, 14'h0);
      chk("loss alarm held", 1, alarm);
      repeat (15) @(negedge clk);
      chk("loss alarm released", 0, alarm);
      $display("test frames done");
      for (int b = 0; b < 14; b++) begin
         slot(0, 14'h1 << b);
         chk("quality alarm", 32'(b != 13), alarm);
         chk("quality warning", 32'(b != 13), warn);
         slot(0, 14'h0);
         repeat (HOLD + 8) @(negedge clk);
      end
      tmode = 1'b1;
      slot(0, 14'h1 << 11);
      chk("test bit alarm", 0, alarm);
      chk("test bit warning", 0, warn);
      tmode = 1'b0;
      $display("test quality done");
      for (int c = 0; c < 2; c++) begin
         if (c == 0) begin
            sk = 1'b0;
         end else begin
            racc = 32'h05F5E101;
         end
         repeat (3) @(negedge clk);
         chk("sync alarm", 1, alarm);
         chk("sync warning", 1, warn);
         sk = 1'b1;
         racc = 32'h0;
         repeat (HOLD - 4) @(negedge clk);
         chk("sync alarm held", 1, alarm);
         repeat (12) @(negedge clk);
         chk("sync alarm released", 0, alarm);
      end
      sacc = 32'h00000FA1;
      repeat (3) @(negedge clk);
      chk("fine warning", 1, warn);
      chk("fine no alarm", 0, alarm);
      sacc = 32'h00000FA0;
      repeat (HOLD + 8) @(negedge clk);
      chk("fine warning released", 0, warn);
      // Reappearing fault must restart the hold
      rk = 1'b0;
      repeat (3) @(negedge clk);
      rk = 1'b1;
      repeat (HOLD - 6) @(negedge clk);
      rk = 1'b0;
      repeat (2) @(negedge clk);
      rk = 1'b1;
      repeat (HOLD - 4) @(negedge clk);
      chk("restarted hold", 1, alarm);
      repeat (12) @(negedge clk);
      chk("restarted hold end", 0, alarm);
      fa_en = 1'b1;
      repeat (3) @(negedge clk);
      chk("adaptivity warning", 1, warn);
      chk("adaptivity alarm", 0, alarm);
      fa_rdy = 1'b1;
      repeat (HOLD + 8) @(negedge clk);
      chk("adaptivity ready", 0, warn);
      $display("test sync done");
      brk = 1'b1;
      @(negedge clk);
      chk("breaker block", 1, vfb);
      brk = 1'b0;
      @(negedge clk);
      chk("breaker clear", 0, vfb);
      $display("test breaker done");
      for (int k = 0; k < 7; k++) begin
         @(negedge clk);
         {opval, panel} = OPS[k][4:1];
         opwr = 1'b1;
         @(negedge clk);
         opwr = 1'b0;
         chk("sender active", 32'(OPS[k][0]), sact);
      end
      $display("test sender done");
      // A shorter wait limit moves the late point; one miss still stays silent
      lim = 16'h0002;
      slot(1, 14'h0);
      slot(2, 14'h0);
      chk("short limit alarm", 0, alarm);
      stall = 1'b1;
      slot(0, 14'h0);
      slot(1, 14'h0);
      // Third word meets a full buffer and must wait, not be lost
      slot(2, 14'h0);
      chk("buffer holds words", 1, ovalid);
      stall = 1'b0;
      for (int n = 0; n < 200 && expq.size() != 0; n++) begin
         @(negedge clk);
      end
      chk("words left", 0, expq.size());
      $display("test buffer done");
      wrap_up();
   end
endmodule
